// File: iirf_pkg.sv
// constants for the measurement filter and buffer input path
// assumes a 32-bit AXI4-Lite register bus, one aligned word a register
package iirf_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_PWR = 8'h00;
  localparam logic [7:0] OFS_FILT = 8'h04;
  localparam logic [7:0] OFS_BUF = 8'h08;
  localparam logic [7:0] OFS_DECIM = 8'h0C;
  localparam logic [7:0] OFS_CNT_LO = 8'h10;
  localparam logic [7:0] OFS_CNT_HI = 8'h14;
  localparam logic [7:0] OFS_DATA = 8'h18;
  localparam logic [7:0] OFS_PRESS = 8'h1C;
  localparam logic [7:0] OFS_TEMP = 8'h20;
  // field positions
  localparam int PWR_PRESS_EN = 0;
  localparam int PWR_TEMP_EN = 1;
  localparam int PWR_MODE_LO = 4;
  localparam int BUF_EN = 0;
  localparam int BUF_P_STORE = 1;
  localparam int BUF_T_STORE = 2;
  localparam int BUF_DSEL_LO = 3;
  localparam int HDR_T_BIT = 4;
  localparam int HDR_P_BIT = 2;
  // encodings
  localparam logic [1:0] MODE_SLEEP = 2'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h3;
  localparam logic [1:0] DSEL_FILT = 2'h1;
  localparam logic [7:0] HDR_SENSOR = 8'h80;
  localparam logic [7:0] EMPTY_DATA = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // reset values
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [2:0] RST_COEF = 3'h0;
  localparam logic [1:0] RST_DSEL = 2'h0;
  localparam logic [2:0] RST_DECIM = 3'h0;
  // buffer geometry
  localparam int BUF_BYTES = 512;
  localparam logic [9:0] BUF_SIZE = 10'h200;
  localparam logic [9:0] FRAME_MAX = 10'h009;
  localparam logic [3:0] LEN_ONE = 4'h4;
  localparam logic [3:0] LEN_TWO = 4'h7;
  localparam logic [3:0] CH_BYTES = 4'h3;
  localparam int DECIM_BITS = 7;
endpackage : iirf_pkg

// File: iirf_chan.sv
// one channel of the recursive low-pass filter
// assumes samples and clears come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module iirf_chan #(
  parameter int W = 24
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // control
  input wire logic i_clear,
  input wire logic i_sample,
  input wire logic [W-1:0] i_raw,
  input wire logic [2:0] i_coef,
  // results
  output logic [W-1:0] o_next,
  output logic [W-1:0] o_value
);
  typedef struct packed {
    logic primed;
    logic [W-1:0] value;
  } iirf_chan_s;

  iirf_chan_s st_q;
  iirf_chan_s st_d;
  logic [W+7:0] acc;

  always_comb begin
    // coefficient is 2^k-1, so dividing by coefficient+1 is a shift
    acc = (({8'h00, st_q.value} << i_coef) - {8'h00, st_q.value}
      + {8'h00, i_raw}) >> i_coef;
    st_d = st_q;
    o_next = st_q.value;
    if (i_sample) begin
      if (i_clear || !st_q.primed) begin
        o_next = i_raw;
      end else begin
        o_next = acc[W-1:0];
      end
      st_d.value = o_next;
      st_d.primed = 1'b1;
    end else if (i_clear) begin
      st_d.primed = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_value = st_q.value;
endmodule : iirf_chan
`default_nettype wire

// File: iirf_top.sv
// filter and buffer input path behind an AXI4-Lite register slave
// assumes converter results arrive on i_clk with a one-cycle done pulse
`timescale 1ns/10ps
`default_nettype none
module iirf_top #(
  parameter int W = 24
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // axi4-lite write channels
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read channels
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // converter side
  input wire logic i_meas_done,
  input wire logic i_press_done,
  input wire logic i_temp_done,
  input wire logic [W-1:0] i_press_raw,
  input wire logic [W-1:0] i_temp_raw,
  output logic [1:0] o_mode,
  output logic o_press_en,
  output logic o_temp_en
);
  typedef struct packed {
    logic awready, wready, bvalid, arready, rvalid, aw_have, w_have;
    logic wstb, press_en, temp_en, buf_en, p_store, t_store, wbusy, eph;
    logic [1:0] bresp, rresp, mode, dsel;
    logic [31:0] rdata;
    logic [7:0] awaddr, wbyte;
    logic [2:0] coef, dexp;
    logic [iirf_pkg::DECIM_BITS-1:0] dcnt;
    logic [8:0] wptr, rptr;
    logic [9:0] count;
    logic [3:0] wlen, widx, rlen, rrem;
    logic [55:0] wbytes;
  } iirf_top_s;

  iirf_top_s st_q;
  iirf_top_s st_d;
  logic [7:0] mem [iirf_pkg::BUF_BYTES];

  logic do_wr, wr_pwr, clr_p, clr_t, smp_p, smp_t;
  logic new_pen, new_ten, to_normal, keep, store_on, put_t, put_p;
  logic [W-1:0] nxt_p, nxt_t, val_p, val_t, sel_t, sel_p;
  logic [1:0] new_mode;
  logic [7:0] hdr, rbyte;
  logic [3:0] flen;
  logic [9:0] add_n, sub_n;
  logic [6:0] dmask;

  ////////////////////////////////////////////////////////////////////////
  // filter channels

  assign smp_p = i_meas_done && i_press_done && st_q.press_en;
  assign smp_t = i_meas_done && i_temp_done && st_q.temp_en;

  iirf_chan #(.W(W)) u_press (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_clear(clr_p),
    .i_sample(smp_p),
    .i_raw(i_press_raw),
    .i_coef(st_q.coef),
    .o_next(nxt_p),
    .o_value(val_p)
  );

  iirf_chan #(.W(W)) u_temp (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_clear(clr_t),
    .i_sample(smp_t),
    .i_raw(i_temp_raw),
    .i_coef(st_q.coef),
    .o_next(nxt_t),
    .o_value(val_t)
  );

  ////////////////////////////////////////////////////////////////////////
  // register write decode and filter restarts

  always_comb begin
    do_wr = st_q.aw_have && st_q.w_have && !st_q.bvalid && st_q.wstb;
    wr_pwr = do_wr && (st_q.awaddr == iirf_pkg::OFS_PWR);
    new_mode = st_q.wbyte[iirf_pkg::PWR_MODE_LO +: 2];
    new_pen = st_q.wbyte[iirf_pkg::PWR_PRESS_EN];
    new_ten = st_q.wbyte[iirf_pkg::PWR_TEMP_EN];
    to_normal = wr_pwr && (st_q.mode == iirf_pkg::MODE_SLEEP)
      && (new_mode == iirf_pkg::MODE_NORMAL);
    clr_p = to_normal;
    clr_p = clr_p || (do_wr && st_q.awaddr == iirf_pkg::OFS_FILT);
    clr_p = clr_p || (wr_pwr && st_q.press_en && !new_pen);
    clr_p = clr_p || (wr_pwr && st_q.temp_en && !new_ten);
    clr_t = clr_p;
    clr_p = clr_p || (wr_pwr && !st_q.press_en && new_pen);
    clr_t = clr_t || (wr_pwr && !st_q.temp_en && new_ten);
  end

  ////////////////////////////////////////////////////////////////////////
  // frame assembly and decimation

  always_comb begin
    dmask = 7'((8'h01 << st_q.dexp) - 8'h01);
    keep = 1'b1;
    if (st_q.mode == iirf_pkg::MODE_NORMAL) begin
      keep = (st_q.dcnt & dmask) == 7'h00;
    end
    store_on = st_q.buf_en && (st_q.p_store || st_q.t_store);
    put_t = smp_t && st_q.t_store;
    put_p = smp_p && st_q.p_store;
    if (st_q.dsel == iirf_pkg::DSEL_FILT) begin
      sel_t = nxt_t;
      sel_p = nxt_p;
    end else begin
      sel_t = i_temp_raw;
      sel_p = i_press_raw;
    end
    hdr = iirf_pkg::HDR_SENSOR;
    hdr[iirf_pkg::HDR_T_BIT] = put_t;
    hdr[iirf_pkg::HDR_P_BIT] = put_p;
    flen = (put_t && put_p) ? iirf_pkg::LEN_TWO : iirf_pkg::LEN_ONE;
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d = st_q;
    rbyte = mem[st_q.rptr];
    add_n = 10'h000;
    sub_n = 10'h000;

    // write address and data taken in either order
    if (i_awvalid && st_q.awready) begin
      st_d.aw_have = 1'b1;
      st_d.awaddr = i_awaddr;
    end
    if (i_wvalid && st_q.wready) begin
      st_d.w_have = 1'b1;
      st_d.wbyte = i_wdata[7:0];
      st_d.wstb = i_wstrb[0];
    end
    if (st_q.bvalid && i_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (st_q.aw_have && st_q.w_have && !st_q.bvalid) begin
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = iirf_pkg::RESP_OKAY;
      if (st_q.awaddr > iirf_pkg::OFS_TEMP || st_q.awaddr[1:0] != 2'h0) begin
        st_d.bresp = iirf_pkg::RESP_SLVERR;
      end
    end

    // single shot falls back to sleep once its measurement is done
    if (i_meas_done && st_q.mode != iirf_pkg::MODE_SLEEP
        && st_q.mode != iirf_pkg::MODE_NORMAL) begin
      st_d.mode = iirf_pkg::MODE_SLEEP;
    end
    if (i_meas_done && st_q.mode == iirf_pkg::MODE_NORMAL) begin
      st_d.dcnt = st_q.dcnt + 7'h01;
    end

    // software writes land after the hardware updates
    if (do_wr) begin
      unique case (st_q.awaddr)
        iirf_pkg::OFS_PWR: begin
          st_d.press_en = new_pen;
          st_d.temp_en = new_ten;
          st_d.mode = new_mode;
          if (to_normal) begin
            st_d.dcnt = '0;
          end
        end
        iirf_pkg::OFS_FILT: begin
          st_d.coef = st_q.wbyte[2:0];
        end
        iirf_pkg::OFS_BUF: begin
          st_d.buf_en = st_q.wbyte[iirf_pkg::BUF_EN];
          st_d.p_store = st_q.wbyte[iirf_pkg::BUF_P_STORE];
          st_d.t_store = st_q.wbyte[iirf_pkg::BUF_T_STORE];
          st_d.dsel = st_q.wbyte[iirf_pkg::BUF_DSEL_LO +: 2];
        end
        iirf_pkg::OFS_DECIM: begin
          st_d.dexp = st_q.wbyte[2:0];
        end
        default: begin
        end
      endcase
    end

    // a new frame starts only on an idle writer with room for any frame
    if (i_meas_done && keep && store_on && (put_t || put_p)
        && !st_q.wbusy
        && (iirf_pkg::BUF_SIZE - st_q.count) >= iirf_pkg::FRAME_MAX) begin
      st_d.wbusy = 1'b1;
      st_d.wlen = flen;
      st_d.widx = 4'h0;
      if (put_t && put_p) begin
        st_d.wbytes = {sel_p, sel_t, hdr};
      end else if (put_t) begin
        st_d.wbytes = {24'h000000, sel_t, hdr};
      end else begin
        st_d.wbytes = {24'h000000, sel_p, hdr};
      end
    end

    // one byte a cycle into the buffer, count grows at the last byte
    if (st_q.wbusy) begin
      st_d.wptr = st_q.wptr + 9'h001;
      st_d.widx = st_q.widx + 4'h1;
      st_d.wbytes = {8'h00, st_q.wbytes[55:8]};
      if (st_q.widx == st_q.wlen - 4'h1) begin
        st_d.wbusy = 1'b0;
        add_n = {6'h00, st_q.wlen};
      end
    end

    // register reads
    if (st_q.rvalid && i_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (i_arvalid && st_q.arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = iirf_pkg::RESP_OKAY;
      st_d.rdata = 32'h00000000;
      unique case (i_araddr)
        iirf_pkg::OFS_PWR: begin
          st_d.rdata[iirf_pkg::PWR_PRESS_EN] = st_q.press_en;
          st_d.rdata[iirf_pkg::PWR_TEMP_EN] = st_q.temp_en;
          st_d.rdata[iirf_pkg::PWR_MODE_LO +: 2] = st_q.mode;
        end
        iirf_pkg::OFS_FILT: st_d.rdata[2:0] = st_q.coef;
        iirf_pkg::OFS_BUF: begin
          st_d.rdata[iirf_pkg::BUF_EN] = st_q.buf_en;
          st_d.rdata[iirf_pkg::BUF_P_STORE] = st_q.p_store;
          st_d.rdata[iirf_pkg::BUF_T_STORE] = st_q.t_store;
          st_d.rdata[iirf_pkg::BUF_DSEL_LO +: 2] = st_q.dsel;
        end
        iirf_pkg::OFS_DECIM: st_d.rdata[2:0] = st_q.dexp;
        iirf_pkg::OFS_CNT_LO: st_d.rdata[7:0] = st_q.count[7:0];
        iirf_pkg::OFS_CNT_HI: st_d.rdata[0] = st_q.count[8];
        iirf_pkg::OFS_DATA: begin
          if (st_q.rrem != 4'h0) begin
            st_d.rdata[7:0] = rbyte;
            st_d.rptr = st_q.rptr + 9'h001;
            st_d.rrem = st_q.rrem - 4'h1;
            if (st_q.rrem == 4'h1) begin
              sub_n = {6'h00, st_q.rlen};
            end
          end else if (st_q.count != 10'h000) begin
            // header byte gives the frame length
            st_d.rdata[7:0] = rbyte;
            st_d.rptr = st_q.rptr + 9'h001;
            st_d.rlen = 4'h1 + (rbyte[iirf_pkg::HDR_T_BIT]
              ? iirf_pkg::CH_BYTES : 4'h0) + (rbyte[iirf_pkg::HDR_P_BIT]
              ? iirf_pkg::CH_BYTES : 4'h0);
            st_d.rrem = st_d.rlen - 4'h1;
          end else begin
            // drained buffer answers with empty frames
            st_d.rdata[7:0] = st_q.eph ? iirf_pkg::EMPTY_DATA
              : iirf_pkg::HDR_SENSOR;
            st_d.eph = !st_q.eph;
          end
        end
        iirf_pkg::OFS_PRESS: st_d.rdata[W-1:0] = val_p;
        iirf_pkg::OFS_TEMP: st_d.rdata[W-1:0] = val_t;
        default: st_d.rresp = iirf_pkg::RESP_SLVERR;
      endcase
    end

    st_d.count = st_q.count + add_n - sub_n;
    st_d.awready = !st_d.aw_have;
    st_d.wready = !st_d.w_have;
    st_d.arready = !st_d.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////
  // state and buffer storage

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q <= '0;
      st_q.mode <= iirf_pkg::RST_MODE;
      st_q.coef <= iirf_pkg::RST_COEF;
      st_q.dsel <= iirf_pkg::RST_DSEL;
      st_q.dexp <= iirf_pkg::RST_DECIM;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (st_q.wbusy) begin
      mem[st_q.wptr] <= st_q.wbytes[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_awready = st_q.awready;
  assign o_wready = st_q.wready;
  assign o_bvalid = st_q.bvalid;
  assign o_bresp = st_q.bresp;
  assign o_arready = st_q.arready;
  assign o_rvalid = st_q.rvalid;
  assign o_rresp = st_q.rresp;
  assign o_rdata = st_q.rdata;
  assign o_mode = st_q.mode;
  assign o_press_en = st_q.press_en;
  assign o_temp_en = st_q.temp_en;
endmodule : iirf_top
`default_nettype wire

// File: iirf_conv_model.sv
// converter stand-in: one done pulse for each request from the bench
// assumes the bench drives requests on the same clock
`timescale 1ns/10ps
`default_nettype none
module iirf_conv_model (
  // clock and request
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [23:0] i_p,
  input wire logic [23:0] i_t,
  // converter outputs
  output logic o_done,
  output logic [23:0] o_p,
  output logic [23:0] o_t
);
  initial begin
    o_done = 1'h0;
    o_p = 24'h0;
    o_t = 24'h0;
  end
  // raw lines are scrambled outside the done cycle
  always @(posedge i_clk) begin
    o_done <= i_go;
    o_p <= i_go ? i_p : ~o_p;
    o_t <= i_go ? i_t : ~o_t;
  end
endmodule : iirf_conv_model
`default_nettype wire

// File: iirf_top_props.sv
// checker for the register bus answers and the mode output
// assumes it is bound to iirf_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module iirf_top_props (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // register bus
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic i_rready,
  // converter side
  input wire logic i_meas_done,
  input wire logic [1:0] o_mode
);
  logic [7:0] ra_q;
  always_ff @(posedge i_clk) begin
    if (i_arvalid && o_arready) begin
      ra_q <= i_araddr;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_rd_taken;
    i_arvalid && o_arready;
  endsequence
  chk_write_answer: assert property (s_wr_taken |-> ##[1:3] o_bvalid)
    else $error("write response late");
  chk_bresp_held: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp)) else $error("write response dropped");
  chk_read_answer: assert property (s_rd_taken |=> o_rvalid)
    else $error("read data late");
  chk_rdata_held: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata)) else $error("read data dropped");
  chk_unmapped_error: assert property (o_rvalid &&
    (ra_q > iirf_pkg::OFS_TEMP || ra_q[1:0] != 2'h0) |->
    o_rresp == iirf_pkg::RESP_SLVERR && o_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_count_high: assert property (
    o_rvalid && ra_q == iirf_pkg::OFS_CNT_HI |-> o_rdata[31:1] == 31'h0)
    else $error("count high holds more than one bit");
  chk_count_low: assert property (
    o_rvalid && ra_q == iirf_pkg::OFS_CNT_LO |-> o_rdata[31:8] == 24'h0)
    else $error("count low wider than a byte");
  chk_single_sleep: assert property (i_meas_done &&
    (o_mode == 2'h1 || o_mode == 2'h2) && o_awready && o_wready |=>
    o_mode == iirf_pkg::MODE_SLEEP) else $error("single shot stayed");
  chk_mode_held: assert property (
    o_awready && o_wready && !i_meas_done |=> $stable(o_mode))
    else $error("mode changed on its own");
  chk_reset_idle: assert property (disable iff (1'h0) i_srst |=>
    !o_bvalid && !o_rvalid && o_mode == iirf_pkg::MODE_SLEEP)
    else $error("outputs busy after reset");
endmodule : iirf_top_props
bind iirf_top iirf_top_props u_props (.i_clk(i_clk), .i_srst(i_srst),
  .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid),
  .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
  .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
  .o_rvalid(o_rvalid), .i_rready(i_rready), .i_meas_done(i_meas_done),
  .o_mode(o_mode));
`default_nettype wire

// File: test_iirf_top.sv
// bench for the filter and buffer path: bus master plus converter model
// assumes the package, converter model and checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module test_iirf_top;
  typedef struct packed {
    logic [2:0] k;
    logic [23:0] pe;
    logic [23:0] te;
  } iirf_row_s;
  iirf_row_s rows [8] = '{'{3'h0, 24'h810, 24'h0}, '{3'h1, 24'h410, 24'h80},
    '{3'h2, 24'h210, 24'hC0}, '{3'h3, 24'h110, 24'hE0},
    '{3'h4, 24'h90, 24'hF0}, '{3'h5, 24'h50, 24'hF8},
    '{3'h6, 24'h30, 24'hFC}, '{3'h7, 24'h20, 24'hFE}};
  logic i_clk = 1'h0;
  logic i_srst = 1'h1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, go = 1'h0;
  logic [31:0] wdata = 32'h0, rv, rdata;
  logic [23:0] gp = 24'h0, gt = 24'h0, praw, traw;
  logic awready, wready, bvalid, arready, rvalid, md, pen, ten;
  logic [1:0] bresp, rresp, mode, rr, wresp;
  int bad_count = 0, comparisons = 0, cyc = 0;
  initial forever #25 i_clk = ~i_clk;
  iirf_conv_model conv (.i_clk(i_clk), .i_go(go), .i_p(gp), .i_t(gt),
    .o_done(md), .o_p(praw), .o_t(traw));
  iirf_top dut (.i_clk(i_clk), .i_srst(i_srst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_meas_done(md), .i_press_done(md), .i_temp_done(md),
    .i_press_raw(praw), .i_temp_raw(traw), .o_mode(mode),
    .o_press_en(pen), .o_temp_en(ten));
  ////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw;
    ta = 0;
    tw = 0;
    @(posedge i_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!(ta && tw)) begin
      @(posedge i_clk);
      if (!ta && awready) begin
        ta = 1;
        awvalid <= 1'h0;
      end
      if (!tw && wready) begin
        tw = 1;
        wvalid <= 1'h0;
      end
    end
    while (!bvalid) @(posedge i_clk);
    bready <= 1'h1;
    @(posedge i_clk);
    wresp = bresp;
    bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge i_clk); while (!arready);
    arvalid <= 1'h0;
    while (!rvalid) @(posedge i_clk);
    rready <= 1'h1;
    @(posedge i_clk);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask : rd
  task automatic cnt_is(input logic [8:0] e);
    logic [31:0] lo;
    rd(iirf_pkg::OFS_CNT_LO, lo, rr);
    rd(iirf_pkg::OFS_CNT_HI, rv, rr);
    chk("count", {23'h0, e}, {23'h0, rv[0], lo[7:0]});
  endtask : cnt_is
  // frame of n bytes is counted n+1 edges after the done pulse
  task automatic fire(input logic [23:0] p, input logic [23:0] t);
    @(posedge i_clk);
    go <= 1'h1;
    gp <= p;
    gt <= t;
    @(posedge i_clk);
    go <= 1'h0;
    repeat (12) @(posedge i_clk);
  endtask : fire
  task automatic frame(input logic [7:0] h, input logic [23:0] t,
    input logic [23:0] p);
    rd(iirf_pkg::OFS_DATA, rv, rr);
    chk("header", {24'h0, h}, rv);
    for (int i = 0; i < 6; i++) begin
      if (i < 3 ? h[4] : h[2]) begin
        rd(iirf_pkg::OFS_DATA, rv, rr);
        chk("data byte", i < 3 ? t[8*i+:8] : p[8*(i-3)+:8], rv);
      end
    end
  endtask : frame
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] e1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'h0;
    cnt_is(9'h0);
    rd(8'h24, rv, rr);
    chk("unmapped resp", iirf_pkg::RESP_SLVERR, rr);
    wr(8'h24, 32'h0);
    chk("unmapped write", iirf_pkg::RESP_SLVERR, wresp);
    $display("reset test done");
    wr(iirf_pkg::OFS_PWR, 32'h33);
    chk("write resp", iirf_pkg::RESP_OKAY, wresp);
    for (int n = 0; n < 8; n++) begin
      wr(iirf_pkg::OFS_FILT, {29'h0, rows[n].k});
      fire(24'h10, 24'h100);
      fire(24'h810, 24'h0);
      rd(iirf_pkg::OFS_PRESS, rv, rr);
      chk("pressure filter", rows[n].pe, rv);
      rd(iirf_pkg::OFS_TEMP, rv, rr);
      chk("temperature filter", rows[n].te, rv);
    end
    $display("filter table done");
    wr(iirf_pkg::OFS_FILT, 32'h3);
    fire(24'h10, 24'h100);
    wr(iirf_pkg::OFS_PWR, 32'h31);
    chk("enables", 32'h1, {30'h0, ten, pen});
    wr(iirf_pkg::OFS_PWR, 32'h33);
    fire(24'h500, 24'h7);
    rd(iirf_pkg::OFS_PRESS, rv, rr);
    chk("restart on disable", 32'h500, rv);
    wr(iirf_pkg::OFS_PWR, 32'h03);
    wr(iirf_pkg::OFS_PWR, 32'h33);
    fire(24'h900, 24'h9);
    rd(iirf_pkg::OFS_TEMP, rv, rr);
    chk("restart on normal", 32'h9, rv);
    $display("filter restart done");
    wr(iirf_pkg::OFS_FILT, 32'h1);
    wr(iirf_pkg::OFS_BUF, 32'h0F);
    fire(24'h10, 24'h100);
    fire(24'h30, 24'h300);
    cnt_is(9'h00E);
    frame(8'h94, 24'h100, 24'h10);
    cnt_is(9'h007);
    frame(8'h94, 24'h200, 24'h20);
    wr(iirf_pkg::OFS_BUF, 32'h05);
    fire(24'h1, 24'hABCDEF);
    wr(iirf_pkg::OFS_BUF, 32'h03);
    fire(24'h123456, 24'h2);
    wr(iirf_pkg::OFS_BUF, 32'h01);
    fire(24'h3, 24'h3);
    cnt_is(9'h008);
    frame(8'h90, 24'hABCDEF, 24'h0);
    frame(8'h84, 24'h0, 24'h123456);
    $display("store test done");
    wr(iirf_pkg::OFS_BUF, 32'h03);
    wr(iirf_pkg::OFS_DECIM, 32'h2);
    wr(iirf_pkg::OFS_PWR, 32'h03);
    wr(iirf_pkg::OFS_PWR, 32'h33);
    repeat (7) fire(24'h55, 24'h0);
    cnt_is(9'h008);
    frame(8'h84, 24'h0, 24'h55);
    frame(8'h84, 24'h0, 24'h55);
    wr(iirf_pkg::OFS_PWR, 32'h13);
    fire(24'h66, 24'h0);
    chk("mode after single", iirf_pkg::MODE_SLEEP, mode);
    cnt_is(9'h004);
    frame(8'h84, 24'h0, 24'h66);
    $display("decimation test done");
    wr(iirf_pkg::OFS_DECIM, 32'h0);
    wr(iirf_pkg::OFS_BUF, 32'h07);
    wr(iirf_pkg::OFS_PWR, 32'h33);
    repeat (73) fire(24'h1, 24'h2);
    cnt_is(9'h1F8);
    repeat (504) rd(iirf_pkg::OFS_DATA, rv, rr);
    cnt_is(9'h0);
    rd(iirf_pkg::OFS_DATA, e1, rr);
    rd(iirf_pkg::OFS_DATA, rv, rr);
    chk("empty frame pair", 32'h80, e1 ^ rv);
    chk("empty frame bits", 32'h80, e1 | rv);
    $display("full test done");
    end_of_test();
  end
endmodule : test_iirf_top
`default_nettype wire
